// ===== logic/lmpsd_decoder.v
// Prefix and size decoder with address generation and address register reads.
// Notes on behaviour
// - Range registers keep and use the full 52-bit address; all 64 bits writable.
// - Addresses read from model registers use the whole value in every mode.
// - Legacy mode software reads and writes all supported upper register bits.
// - Extension prefix matters only for extended registers or 64-bit operands.
// - A meaningless extension prefix is ignored; instruction runs unchanged.
// - Wide mode near branches and stack users except far branches default 64-bit.
// - Wide mode data, extra, stack, code overrides are null and uncounted.
// - Wide mode upper-base overrides stay active and add the segment base.
// - Wide mode operands default 32; extension W gives 64; 66h gives 16.
// - Extension W wins over 66h.
// - Wide mode 32-bit register writes clear bits 63 to 32.
// - 8 and 16-bit register writes keep the upper bits.
// - Wide mode addresses default 64; 67h gives 32.
// - No 16-bit addresses in wide mode.
// - Compatibility and legacy address prefix acts as in the older architecture.
// - Displacements are 32-bit sign-extended, except wide move forms.
// - Addresses truncate to effective size and zero-extend to 64.
// - Wide mode pointer-relative address is next instruction address plus displacement.
// - Wide mode stack instructions never use 32 bits; 66h gives 16.
// - Flag push and pop 9C and 9D are 64-bit-default stack instructions.
// - Frame create C8 and delete C9 are 64-bit-default stack instructions.
// - 8F/0, FF/6, 50-57, 58-5F are 64-bit-default stack instructions.
// - Wide mode one-byte increment and decrement codes are extension prefixes.
`timescale 1ns/1ps
`default_nettype none
`include "lmpsd_consts.vh"
module lmpsd_decoder #(
	parameter PA_BITS = `LMPSD_PA_BITS
) (
	input  wire        i_clk_sys,
	input  wire        i_nrst,
	input  wire        i_valid,
	input  wire [1:0]  i_mode,
	input  wire        i_cs_default32,
	input  wire [7:0]  i_pfx0,
	input  wire [7:0]  i_pfx1,
	input  wire [7:0]  i_pfx2,
	input  wire [7:0]  i_pfx3,
	input  wire [2:0]  i_pfx_count,
	input  wire [7:0]  i_opcode,
	input  wire [7:0]  i_opcode2,
	input  wire [2:0]  i_modrm_reg,
	input  wire        i_uses_ext_reg,
	input  wire        i_ip_rel,
	input  wire        i_has_mem,
	input  wire [63:0] i_base,
	input  wire [63:0] i_index_scaled,
	input  wire [63:0] i_disp,
	input  wire [63:0] i_next_ip,
	input  wire [63:0] i_seg_a_base,
	input  wire [63:0] i_seg_b_base,
	input  wire [63:0] i_seg_legacy_base,
	input  wire [63:0] i_gr_old,
	input  wire [63:0] i_gr_result,
	input  wire        i_gr_wr,
	input  wire        i_gr_byte,
	input  wire        i_msr_wr,
	input  wire        i_msr_rd,
	input  wire [63:0] i_msr_wdata,
	output reg         o_valid,
	output reg  [1:0]  o_op_size,
	output reg  [1:0]  o_addr_size,
	output reg  [2:0]  o_seg_sel,
	output reg         o_stack_op,
	output reg         o_rexp_used,
	output reg  [3:0]  o_rexp_bits,
	output reg  [2:0]  o_pfx_count_eff,
	output reg  [63:0] o_eff_addr,
	output reg         o_gr_wr,
	output reg  [63:0] o_gr_value,
	output reg  [63:0] o_msr_rdata,
	output reg  [63:0] o_memory_type_range_regs_phys_addr
);
	wire        wide;
	wire [7:0]  pfx [0:3];
	wire [3:0]  is_null_seg;
	wire [3:0]  is_rexp;
	wire [3:0]  is_opsz;
	wire [3:0]  is_adsz;
	wire [3:0]  is_sega;
	wire [3:0]  is_segb;
	wire [3:0]  is_segl;
	reg  [3:0]  rexp_val;
	reg         rexp_seen;
	reg  [2:0]  null_cnt;
	reg         stack_op;
	reg         near_br;
	reg         wide_move;
	reg  [1:0]  op_size;
	reg  [1:0]  addr_size;
	reg  [2:0]  seg_sel;
	reg  [63:0] seg_base;
	reg  [63:0] msr_reg;
	reg  [1:0]  gr_size;
	wire [63:0] eff_addr;
	wire [63:0] merged;
	integer     k;

	assign wide   = (i_mode == `LMPSD_MODE_WIDE);
	assign pfx[0] = i_pfx0;
	assign pfx[1] = i_pfx1;
	assign pfx[2] = i_pfx2;
	assign pfx[3] = i_pfx3;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_pfx
			wire present = (i_pfx_count > g);
			assign is_null_seg[g] = present && wide && ((pfx[g] == `LMPSD_PFX_ES) ||
			                        (pfx[g] == `LMPSD_PFX_CS) || (pfx[g] == `LMPSD_PFX_SS) ||
			                        (pfx[g] == `LMPSD_PFX_DS));
			assign is_rexp[g]     = present && wide && (pfx[g][7:4] == `LMPSD_REXP_HI);
			assign is_opsz[g]     = present && (pfx[g] == `LMPSD_PFX_OPSZ);
			assign is_adsz[g]     = present && (pfx[g] == `LMPSD_PFX_ADSZ);
			assign is_sega[g]     = present && (pfx[g] == `LMPSD_PFX_SEGA);
			assign is_segb[g]     = present && (pfx[g] == `LMPSD_PFX_SEGB);
			assign is_segl[g]     = present && !wide && ((pfx[g] == `LMPSD_PFX_ES) ||
			                        (pfx[g] == `LMPSD_PFX_CS) || (pfx[g] == `LMPSD_PFX_SS) ||
			                        (pfx[g] == `LMPSD_PFX_DS));
		end
	endgenerate

	// The extension prefix only counts when it is the last prefix; an earlier one is dropped.
	always @* begin
		rexp_val  = 4'h0;
		rexp_seen = 1'b0;
		null_cnt  = 3'h0;
		for (k = 0; k < 4; k = k + 1) begin
			if (is_null_seg[k]) begin
				null_cnt = null_cnt + 3'h1;
			end
			if (is_rexp[k]) begin
				rexp_seen = 1'b1;
				rexp_val  = pfx[k][3:0];
			end else if (i_pfx_count > k[2:0]) begin
				rexp_seen = 1'b0;
				rexp_val  = 4'h0;
			end
		end
	end

	// Stack-implicit and near-branch classification.
	always @* begin
		stack_op = 1'b0;
		near_br  = 1'b0;
		case (i_opcode)
			`LMPSD_OP_PUSH_FLAGS, `LMPSD_OP_POP_FLAGS: stack_op = 1'b1;
			`LMPSD_OP_ENTER, `LMPSD_OP_LEAVE: stack_op = 1'b1;
			`LMPSD_OP_POPRM: stack_op = (i_modrm_reg == `LMPSD_MODRM_POP);
			`LMPSD_OP_PUSHI32, `LMPSD_OP_PUSHI8: stack_op = 1'b1;
			`LMPSD_OP_GRP5: begin
				stack_op = (i_modrm_reg == `LMPSD_MODRM_PUSH);
				near_br  = (i_modrm_reg == `LMPSD_MODRM_CALLI) ||
				           (i_modrm_reg == `LMPSD_MODRM_JMPI);
			end
			`LMPSD_OP_ESC: stack_op = (i_opcode2 == `LMPSD_OP2_PUSHSA) ||
			                          (i_opcode2 == `LMPSD_OP2_POPSA) ||
			                          (i_opcode2 == `LMPSD_OP2_PUSHSB) ||
			                          (i_opcode2 == `LMPSD_OP2_POPSB);
			`LMPSD_OP_CALLN, `LMPSD_OP_JMPN, `LMPSD_OP_JMPS,
			`LMPSD_OP_RETN, `LMPSD_OP_RETNI: near_br = 1'b1;
			default: begin
				stack_op = (i_opcode[7:3] == `LMPSD_OP_PUSHR_HI) ||
				           (i_opcode[7:3] == `LMPSD_OP_POPR_HI);
				near_br  = (i_opcode[7:4] == 4'h7) || (i_opcode[7:2] == 6'h38) ||
				           (i_opcode2[7:4] == 4'h8 && i_opcode == `LMPSD_OP_ESC);
			end
		endcase
		if (i_opcode == `LMPSD_OP_ESC && i_opcode2[7:4] == 4'h8) begin
			near_br = 1'b1;
		end
	end

	// Operand size resolution.
	always @* begin
		if (wide) begin
			if ((stack_op || near_br) && !rexp_val[`LMPSD_REXP_W_BIT]) begin
				op_size = (|is_opsz) ? `LMPSD_SZ_16 : `LMPSD_SZ_64;
			end else if (rexp_seen && rexp_val[`LMPSD_REXP_W_BIT]) begin
				op_size = `LMPSD_SZ_64;
			end else if (|is_opsz) begin
				op_size = `LMPSD_SZ_16;
			end else begin
				op_size = `LMPSD_SZ_32;
			end
		end else begin
			op_size = ((|is_opsz) ^ i_cs_default32) ? `LMPSD_SZ_32 : `LMPSD_SZ_16;
		end
	end

	// Address size resolution; the wide mode has no 16-bit choice.
	always @* begin
		if (wide) begin
			addr_size = (|is_adsz) ? `LMPSD_SZ_32 : `LMPSD_SZ_64;
		end else begin
			addr_size = ((|is_adsz) ^ i_cs_default32) ? `LMPSD_SZ_32 : `LMPSD_SZ_16;
		end
	end

	// Segment selection; the last override wins.
	always @* begin
		seg_sel  = `LMPSD_SEG_NONE;
		seg_base = 64'h0000_0000_0000_0000;
		for (k = 0; k < 4; k = k + 1) begin
			if (is_sega[k]) begin
				seg_sel = `LMPSD_SEG_A;
			end else if (is_segb[k]) begin
				seg_sel = `LMPSD_SEG_B;
			end else if (is_segl[k]) begin
				seg_sel = `LMPSD_SEG_LEGACY;
			end
		end
		case (seg_sel)
			`LMPSD_SEG_A: seg_base = wide ? i_seg_a_base : {32'h0000_0000, i_seg_a_base[31:0]};
			`LMPSD_SEG_B: seg_base = wide ? i_seg_b_base : {32'h0000_0000, i_seg_b_base[31:0]};
			`LMPSD_SEG_LEGACY: seg_base = {32'h0000_0000, i_seg_legacy_base[31:0]};
			default: seg_base = 64'h0000_0000_0000_0000;
		endcase
		wide_move = wide && ((i_opcode[7:2] == 6'h28) ||
		            (i_opcode[7:3] == `LMPSD_OP_MOVRI_HI && rexp_val[`LMPSD_REXP_W_BIT]));
		gr_size = i_gr_byte ? `LMPSD_SZ_8 : op_size;
	end

	lmpsd_addr_gen u_addr_gen (
		.i_base         (i_base),
		.i_index_scaled (i_index_scaled),
		.i_seg_base     (seg_base),
		.i_next_ip      (i_next_ip),
		.i_disp         (i_disp),
		.i_disp_wide    (wide_move),
		.i_ip_rel       (i_ip_rel && wide),
		.i_seg_add      (i_has_mem && seg_sel != `LMPSD_SEG_NONE),
		.i_addr_size    (addr_size),
		.o_addr         (eff_addr)
	);

	lmpsd_result_merge u_merge (
		.i_old       (i_gr_old),
		.i_result    (i_gr_result),
		.i_size      (gr_size),
		.i_wide_mode (wide),
		.o_merged    (merged)
	);

	// Address-holding model register: every bit is writable in all modes.
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			msr_reg <= `LMPSD_MSR_ZERO;
		end else if (i_msr_wr) begin
			msr_reg <= i_msr_wdata;
		end
	end

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_valid          <= 1'b0;
			o_op_size        <= `LMPSD_SZ_32;
			o_addr_size      <= `LMPSD_SZ_64;
			o_seg_sel        <= `LMPSD_SEG_NONE;
			o_stack_op       <= 1'b0;
			o_rexp_used      <= 1'b0;
			o_rexp_bits      <= 4'h0;
			o_pfx_count_eff  <= 3'h0;
			o_eff_addr       <= 64'h0000_0000_0000_0000;
			o_gr_wr          <= 1'b0;
			o_gr_value       <= 64'h0000_0000_0000_0000;
			o_msr_rdata      <= 64'h0000_0000_0000_0000;
			o_memory_type_range_regs_phys_addr <= 64'h0000_0000_0000_0000;
		end else begin
			o_valid          <= i_valid;
			o_op_size        <= op_size;
			o_addr_size      <= addr_size;
			o_seg_sel        <= seg_sel;
			o_stack_op       <= stack_op && wide;
			// Prefix has effect only when it names an extended register or wide operand.
			o_rexp_used      <= rexp_seen && (i_uses_ext_reg || rexp_val[`LMPSD_REXP_W_BIT]);
			o_rexp_bits      <= rexp_seen ? rexp_val : 4'h0;
			o_pfx_count_eff  <= i_pfx_count - null_cnt;
			o_eff_addr       <= eff_addr;
			o_gr_wr          <= i_gr_wr;
			o_gr_value       <= merged;
			if (i_msr_rd) begin
				o_msr_rdata <= msr_reg;
			end
			o_memory_type_range_regs_phys_addr <= {{(64 - PA_BITS){1'b0}}, msr_reg[PA_BITS-1:0]};
		end
	end
endmodule
`default_nettype wire

// ===== include/lmpsd_consts.vh
// Constants for the wide-mode prefix and size decoder.
`ifndef LMPSD_CONSTS_VH
`define LMPSD_CONSTS_VH
`define LMPSD_MODE_LEGACY   2'h0
`define LMPSD_MODE_COMPAT   2'h1
`define LMPSD_MODE_WIDE     2'h2
`define LMPSD_SZ_16         2'h0
`define LMPSD_SZ_32         2'h1
`define LMPSD_SZ_64         2'h2
`define LMPSD_SZ_8          2'h3
`define LMPSD_SEG_NONE      3'h0
`define LMPSD_SEG_A         3'h1
`define LMPSD_SEG_B         3'h2
`define LMPSD_SEG_LEGACY    3'h3
`define LMPSD_PFX_OPSZ      8'h66
`define LMPSD_PFX_ADSZ      8'h67
`define LMPSD_PFX_ES        8'h26
`define LMPSD_PFX_CS        8'h2E
`define LMPSD_PFX_SS        8'h36
`define LMPSD_PFX_DS        8'h3E
`define LMPSD_PFX_SEGA      8'h64
`define LMPSD_PFX_SEGB      8'h65
`define LMPSD_REXP_HI       4'h4
`define LMPSD_REXP_W_BIT    3
`define LMPSD_OP_PUSH_FLAGS      8'h9C
`define LMPSD_OP_POP_FLAGS       8'h9D
`define LMPSD_OP_ENTER      8'hC8
`define LMPSD_OP_LEAVE      8'hC9
`define LMPSD_OP_POPRM      8'h8F
`define LMPSD_OP_GRP5       8'hFF
`define LMPSD_OP_PUSHR_HI   5'h0A
`define LMPSD_OP_POPR_HI    5'h0B
`define LMPSD_OP_PUSHI32    8'h68
`define LMPSD_OP_PUSHI8     8'h6A
`define LMPSD_OP_ESC        8'h0F
`define LMPSD_OP2_PUSHSA    8'hA0
`define LMPSD_OP2_POPSA     8'hA1
`define LMPSD_OP2_PUSHSB    8'hA8
`define LMPSD_OP2_POPSB     8'hA9
`define LMPSD_OP_CALLN      8'hE8
`define LMPSD_OP_JMPN       8'hE9
`define LMPSD_OP_JMPS       8'hEB
`define LMPSD_OP_RETN       8'hC3
`define LMPSD_OP_RETNI      8'hC2
`define LMPSD_OP_MOVABS     8'hA0
`define LMPSD_OP_MOVRI_HI   5'h17
`define LMPSD_MODRM_POP     3'h0
`define LMPSD_MODRM_PUSH    3'h6
`define LMPSD_MODRM_CALLI   3'h2
`define LMPSD_MODRM_JMPI    3'h4
`define LMPSD_PA_BITS       52
`define LMPSD_MSR_ZERO      64'h0000_0000_0000_0000
`endif

// ===== logic/lmpsd_addr_gen.v
// Effective address adder with displacement sizing, truncation and zero extension.
`timescale 1ns/1ps
`default_nettype none
`include "lmpsd_consts.vh"
module lmpsd_addr_gen (
	input  wire [63:0] i_base,
	input  wire [63:0] i_index_scaled,
	input  wire [63:0] i_seg_base,
	input  wire [63:0] i_next_ip,
	input  wire [63:0] i_disp,
	input  wire        i_disp_wide,
	input  wire        i_ip_rel,
	input  wire        i_seg_add,
	input  wire [1:0]  i_addr_size,
	output wire [63:0] o_addr
);
	wire [63:0] disp_ext;
	wire [63:0] base_sel;
	wire [63:0] sum;
	wire [63:0] trunc;
	// Only the move forms may carry a full width displacement.
	assign disp_ext = i_disp_wide ? i_disp : {{32{i_disp[31]}}, i_disp[31:0]};
	assign base_sel = i_ip_rel ? i_next_ip : i_base;
	assign sum      = base_sel + (i_ip_rel ? 64'h0000_0000_0000_0000 : i_index_scaled) + disp_ext;
	assign trunc    = (i_addr_size == `LMPSD_SZ_64) ? sum :
	                  (i_addr_size == `LMPSD_SZ_32) ? {32'h0000_0000, sum[31:0]} :
	                  {48'h0000_0000_0000, sum[15:0]};
	// Segment base is added after truncation so the upper bases reach full width.
	assign o_addr   = trunc + (i_seg_add ? i_seg_base : 64'h0000_0000_0000_0000);
endmodule
`default_nettype wire

// ===== logic/lmpsd_result_merge.v
// Writes a sized result into a general register value.
`timescale 1ns/1ps
`default_nettype none
`include "lmpsd_consts.vh"
module lmpsd_result_merge (
	input  wire [63:0] i_old,
	input  wire [63:0] i_result,
	input  wire [1:0]  i_size,
	input  wire        i_wide_mode,
	output reg  [63:0] o_merged
);
	always @* begin
		case (i_size)
			`LMPSD_SZ_8:  o_merged = {i_old[63:8], i_result[7:0]};
			`LMPSD_SZ_16: o_merged = {i_old[63:16], i_result[15:0]};
			// Outside the wide mode the upper half is not architecturally visible.
			`LMPSD_SZ_32: o_merged = i_wide_mode ? {32'h0000_0000, i_result[31:0]}
			                                     : {i_old[63:32], i_result[31:0]};
			default:      o_merged = i_result;
		endcase
	end
endmodule
`default_nettype wire

// ===== verification/lmpsd_decoder_chk.sv
// Port-level checker for the prefix and size decoder.
`timescale 1ns/1ps
`default_nettype none
module lmpsd_decoder_chk (
	input wire logic        i_clk_sys,
	input wire logic        i_nrst,
	input wire logic        i_valid,
	input wire logic [1:0]  i_mode,
	input wire logic [2:0]  i_pfx_count,
	input wire logic [7:0]  i_pfx0,
	input wire logic [7:0]  i_opcode,
	input wire logic        i_gr_wr,
	input wire logic        i_gr_byte,
	input wire logic [63:0] i_gr_old,
	input wire logic        i_msr_wr,
	input wire logic        i_msr_rd,
	input wire logic [63:0] i_msr_wdata,
	input wire logic [1:0]  o_op_size,
	input wire logic [1:0]  o_addr_size,
	input wire logic [2:0]  o_seg_sel,
	input wire logic        o_stack_op,
	input wire logic [2:0]  o_pfx_count_eff,
	input wire logic [63:0] o_gr_value,
	input wire logic [63:0] o_msr_rdata
);
	logic ww;
	logic w0;
	logic w1;
	assign ww = i_valid && i_mode == 2'h2;
	assign w0 = ww && i_pfx_count == 3'h0;
	assign w1 = ww && i_pfx_count == 3'h1;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	op_ext_wide_a:
		assert property (w1 && i_pfx0[7:4] == 4'h4 && i_pfx0[3] |=> o_op_size == 2'h2)
		else $error("extension prefix did not give 64-bit operands");
	op_pfx16_a:
		assert property (w1 && i_pfx0 == 8'h66 |=> o_op_size == 2'h0)
		else $error("size prefix did not give 16-bit operands");
	op_default_a:
		assert property (w0 && i_opcode == 8'h01 |=> o_op_size == 2'h1)
		else $error("default operand size is not 32");
	stack_wide_a:
		assert property (w0 && (i_opcode inside {8'h9C, 8'h9D, 8'hC8, 8'hC9} ||
			i_opcode[7:4] == 4'h5) |=> o_op_size == 2'h2 && o_stack_op)
		else $error("stack instruction not 64-bit by default");
	addr_wide_a:
		assert property (w0 |=> o_addr_size == 2'h2)
		else $error("wide default address size is not 64");
	addr_no16_a:
		assert property (ww |=> o_addr_size != 2'h0)
		else $error("16-bit address size in wide mode");
	null_seg_a:
		assert property (w1 && i_pfx0 inside {8'h26, 8'h2E, 8'h36, 8'h3E}
			|=> o_seg_sel == 3'h0 && o_pfx_count_eff == 3'h0)
		else $error("null segment prefix took effect or was counted");
	seg_keep_a:
		assert property (w1 && i_pfx0 == 8'h64 |=> o_seg_sel == 3'h1)
		else $error("upper-base segment prefix dropped");
	zext32_a:
		assert property (w0 && i_opcode == 8'h01 && i_gr_wr && !i_gr_byte
			|=> o_gr_value[63:32] == 32'h0000_0000)
		else $error("32-bit result not zero-extended");
	byte_keep_a:
		assert property (i_valid && i_gr_wr && i_gr_byte
			|=> (o_gr_value >> 8) == ($past(i_gr_old) >> 8))
		else $error("8-bit write changed upper bits");
	msr_whole_a:
		assert property (i_msr_wr ##1 i_msr_rd |=> o_msr_rdata == $past(i_msr_wdata, 2))
		else $error("address register read differs from written value");
endmodule
bind lmpsd_decoder lmpsd_decoder_chk u_lmpsd_decoder_chk (
	.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_valid(i_valid), .i_mode(i_mode),
	.i_pfx_count(i_pfx_count), .i_pfx0(i_pfx0), .i_opcode(i_opcode), .i_gr_wr(i_gr_wr),
	.i_gr_byte(i_gr_byte), .i_gr_old(i_gr_old), .i_msr_wr(i_msr_wr), .i_msr_rd(i_msr_rd),
	.i_msr_wdata(i_msr_wdata), .o_op_size(o_op_size), .o_addr_size(o_addr_size),
	.o_seg_sel(o_seg_sel), .o_stack_op(o_stack_op), .o_pfx_count_eff(o_pfx_count_eff),
	.o_gr_value(o_gr_value), .o_msr_rdata(o_msr_rdata));
`default_nettype wire

// ===== verification/lmpsd_fetch_model.sv
// Fetch-side model that presents one instruction with up to two prefixes per table entry.
`timescale 1ns/1ps
`default_nettype none
module lmpsd_fetch_model (
	input  wire logic [4:0] i_sel,
	output logic [1:0]      o_mode,
	output logic            o_cs32,
	output logic [2:0]      o_cnt,
	output logic [7:0]      o_pfx0,
	output logic [7:0]      o_pfx1,
	output logic [7:0]      o_opcode,
	output logic [7:0]      o_opcode2,
	output logic [2:0]      o_modrm_reg
);
	logic [23:0] row;
	always_comb begin
		case (i_sel)
			5'h01: row = 24'h66_0001;
			5'h02: row = 24'h48_0001;
			5'h03: row = 24'h66_4801;
			5'h04, 5'h12, 5'h14: row = 24'h67_0001;
			5'h05: row = 24'h00_009C;
			5'h06: row = 24'h66_009D;
			5'h07: row = 24'h00_00C8;
			5'h08: row = 24'h00_00C9;
			5'h09: row = 24'h00_008F;
			5'h0A: row = 24'h00_00FF;
			5'h0B: row = 24'h00_0050;
			5'h0C: row = 24'h00_005F;
			5'h0D: row = 24'h26_0001;
			5'h0E: row = 24'h3E_0001;
			5'h0F: row = 24'h65_0001;
			5'h10: row = 24'h00_00EB;
			5'h15: row = 24'h40_0001;
			5'h16: row = 24'h64_0001;
			5'h17: row = 24'h36_0001;
			5'h18: row = 24'h2E_0001;
			5'h19: row = 24'h00_000F;
			default: row = 24'h00_0001;
		endcase
		{o_pfx0, o_pfx1, o_opcode} = row;
		// The extension prefix always sits last, the only place where it counts.
		o_cnt = {2'h0, o_pfx0 != 8'h00} + {2'h0, o_pfx1 != 8'h00};
		o_mode = (i_sel == 5'h11 || i_sel == 5'h12) ? 2'h0 :
			(i_sel == 5'h13 || i_sel == 5'h14) ? 2'h1 : 2'h2;
		o_cs32 = i_sel < 5'h13;
		o_opcode2 = (o_opcode == 8'h0F) ? 8'hA0 : 8'h00;
		o_modrm_reg = (o_opcode == 8'hFF) ? 3'h6 : 3'h0;
	end
endmodule
`default_nettype wire

// ===== verification/lmpsd_decoder_test.sv
// Self-checking bench for the prefix and size decoder.
`timescale 1ns/1ps
`default_nettype none
module lmpsd_decoder_test;
	localparam logic [63:0] BASE = 64'hFFFF_FFFF_FFFF_FFF0;
	localparam logic [63:0] IDX  = 64'h0000_0000_0000_0020;
	localparam logic [63:0] DSP  = 64'h0000_0000_8000_0000;
	localparam logic [63:0] SX   = 64'hFFFF_FFFF_8000_0000;
	localparam logic [63:0] NIP  = 64'h0000_7000_0000_0000;
	localparam logic [63:0] SGA  = 64'h0000_1000_0000_0000;
	localparam logic [63:0] SGB  = 64'h0000_2000_0000_0000;
	localparam logic [63:0] OLD  = 64'hAAAA_BBBB_CCCC_DDDD;
	localparam logic [63:0] RES  = 64'h1234_5678_9ABC_DEF0;
	logic        i_clk_sys, i_nrst, ip_rel, gr_byte, msr_wr, msr_rd;
	logic        vld, ext, rexp_used;
	logic [4:0]  sel;
	logic [63:0] msr_wd;
	logic [1:0]  mode, o_op_size, o_addr_size;
	logic        cs32, o_valid, o_stack_op;
	logic [2:0]  cnt, mrm, o_seg_sel, o_pfx_count_eff;
	logic [7:0]  p0, p1, op, op2;
	logic [63:0] o_eff_addr, o_gr_value, o_msr_rdata, o_memory_type_range_regs_phys_addr;
	int          errors, cmp_count;
	lmpsd_fetch_model u_lmpsd_fetch_model (.i_sel(sel), .o_mode(mode), .o_cs32(cs32),
		.o_cnt(cnt), .o_pfx0(p0), .o_pfx1(p1), .o_opcode(op), .o_opcode2(op2),
		.o_modrm_reg(mrm));
	lmpsd_decoder u_lmpsd_decoder (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_valid(vld),
		.i_mode(mode), .i_cs_default32(cs32), .i_pfx0(p0), .i_pfx1(p1), .i_pfx2(8'h00),
		.i_pfx3(8'h00), .i_pfx_count(cnt), .i_opcode(op), .i_opcode2(op2),
		.i_modrm_reg(mrm), .i_uses_ext_reg(ext), .i_ip_rel(ip_rel), .i_has_mem(1'b1),
		.i_base(BASE), .i_index_scaled(IDX), .i_disp(DSP), .i_next_ip(NIP),
		.i_seg_a_base(SGA), .i_seg_b_base(SGB), .i_seg_legacy_base(64'h0000_0000_0000_0000),
		.i_gr_old(OLD), .i_gr_result(RES), .i_gr_wr(1'b1), .i_gr_byte(gr_byte),
		.i_msr_wr(msr_wr), .i_msr_rd(msr_rd), .i_msr_wdata(msr_wd), .o_valid(o_valid),
		.o_op_size(o_op_size), .o_addr_size(o_addr_size), .o_seg_sel(o_seg_sel),
		.o_stack_op(o_stack_op), .o_rexp_used(rexp_used), .o_rexp_bits(),
		.o_pfx_count_eff(o_pfx_count_eff), .o_eff_addr(o_eff_addr), .o_gr_wr(),
		.o_gr_value(o_gr_value), .o_msr_rdata(o_msr_rdata),
		.o_memory_type_range_regs_phys_addr(o_memory_type_range_regs_phys_addr));
	task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Expected {operand size, address size, segment, effective prefix count} per row.
	function automatic logic [9:0] exp_of(input logic [4:0] s);
		case (s)
			5'h01, 5'h06: exp_of = 10'h081;
			5'h02: exp_of = 10'h281;
			5'h03: exp_of = 10'h282;
			5'h04: exp_of = 10'h141;
			5'h0F: exp_of = 10'h191;
			5'h11: exp_of = 10'h140;
			5'h12: exp_of = 10'h101;
			5'h13: exp_of = 10'h000;
			5'h14: exp_of = 10'h041;
			5'h15: exp_of = 10'h181;
			5'h16: exp_of = 10'h189;
			5'h00, 5'h0D, 5'h0E, 5'h17, 5'h18: exp_of = 10'h180;
			default: exp_of = 10'h280;
		endcase
	endfunction
	task dec(input logic [4:0] s, input logic rel, input logic byt);
		logic [9:0]  e;
		logic [63:0] g;
		logic [63:0] a;
		logic [63:0] sum;
		logic        w;
		@(posedge i_clk_sys);
		sel <= s;
		vld <= 1'b1;
		// An extended register is named only on the pointer-relative call, which has no prefix.
		ext <= rel;
		ip_rel <= rel;
		gr_byte <= byt;
		@(posedge i_clk_sys);
		#1;
		e = exp_of(s);
		w = s < 5'h11 || s > 5'h14;
		sum = BASE + IDX + SX;
		g = (e[9:8] == 2'h2) ? RES : (e[9:8] == 2'h0) ? {OLD[63:16], RES[15:0]} :
			w ? {32'h0000_0000, RES[31:0]} : {OLD[63:32], RES[31:0]};
		if (byt) g = {OLD[63:8], RES[7:0]};
		a = rel ? NIP + SX : (e[7:6] == 2'h1) ? {32'h0000_0000, sum[31:0]} : sum;
		a = a + ((e[5:3] == 3'h1) ? SGA : (e[5:3] == 3'h2) ? SGB : 64'h0000_0000_0000_0000);
		chk("valid", 64'(o_valid), 64'h0000_0000_0000_0001);
		chk("sizes", 64'({o_op_size, o_addr_size, o_seg_sel, o_pfx_count_eff}), 64'(e));
		if (s != 5'h10) chk("stack", 64'(o_stack_op), 64'((s >= 5'h05 && s <= 5'h0C) || s == 5'h19));
		chk("gr_value", o_gr_value, g);
		chk("rexp_used", 64'(rexp_used), 64'(s == 5'h02 || s == 5'h03));
		if (w) chk("eff_addr", o_eff_addr, a);
	endtask
	// Write strobe is followed at once by a read, as the bus allows.
	task msr_wr_rd(input logic [63:0] d);
		@(posedge i_clk_sys);
		msr_wr <= 1'b1;
		msr_wd <= d;
		@(posedge i_clk_sys);
		msr_wr <= 1'b0;
		msr_rd <= 1'b1;
		@(posedge i_clk_sys);
		msr_rd <= 1'b0;
		#1;
		chk("msr_rdata", o_msr_rdata, d);
		@(posedge i_clk_sys);
		#1;
		chk("memory_type_range_regs_addr", o_memory_type_range_regs_phys_addr, {12'h000, d[51:0]});
	endtask
	task tally_and_finish;
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		repeat (2000) @(posedge i_clk_sys);
		errors++;
		tally_and_finish;
	end
	initial begin
		i_nrst = 1'b0;
		sel = 5'h00;
		ip_rel = 1'b0;
		vld = 1'b0;
		ext = 1'b0;
		gr_byte = 1'b0;
		msr_wr = 1'b0;
		msr_rd = 1'b0;
		msr_wd = 64'h0000_0000_0000_0000;
		errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge i_clk_sys);
		chk("reset_sizes", 64'({o_op_size, o_addr_size}), 64'h0000_0000_0000_0006);
		i_nrst <= 1'b1;
		for (int s = 0; s < 26; s++) begin
			dec(5'(s), 1'b0, 1'b0);
		end
		dec(5'h00, 1'b1, 1'b0);
		dec(5'h00, 1'b0, 1'b1);
		dec(5'h11, 1'b0, 1'b0);
		msr_wr_rd(64'hFFFF_F123_4567_89AB);
		dec(5'h02, 1'b0, 1'b0);
		msr_wr_rd(64'h8000_0ABC_DEF0_1234);
		tally_and_finish;
	end
endmodule
`default_nettype wire
